/* File: rtl/serial_channel_map.vh */
/*
 * Register offsets, field positions, reset values and timing counts for
 * the serial channel format and clock select block.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
`ifndef SERIAL_CHANNEL_MAP_VH
`define SERIAL_CHANNEL_MAP_VH

// =====================================================================
// Register byte offsets
`define OFS_STIMER_CTRL   12'h000
`define OFS_FORMAT        12'h004
`define OFS_CTRL          12'h008
`define OFS_DIVISOR       12'h00C
`define OFS_TXDATA        12'h010
`define OFS_RXDATA        12'h014
`define OFS_STATUS        12'h018

// =====================================================================
// Reset values
`define RST_STIMER_CTRL   8'h00
`define RST_FORMAT        8'h00
`define RST_CTRL          8'h00
`define RST_DIVISOR       8'h00
`define RST_STATUS        8'h84

// =====================================================================
// Field positions
`define STC_MPE_BIT       2
`define FMT_SYNC_BIT      7
`define FMT_CHR_BIT       6
`define FMT_PAR_BIT       5
`define FMT_ODD_BIT       4
`define FMT_STOP_BIT      3
`define FMT_MP_BIT        2
`define CTL_TXEN_BIT      5
`define CTL_RXEN_BIT      4
`define CTL_EXTERNAL_CLOCK_SELECT_BIT      1
`define CTL_CLOCK_OUTPUT_SELECT_BIT      0
`define STS_TXEMPTY_BIT   7
`define STS_RXFULL_BIT    6
`define STS_OVR_BIT       5
`define STS_FRM_BIT       4
`define STS_PAR_BIT       3
`define STS_TEND_BIT      2
`define STS_MPB_BIT       1
`define STS_MPBT_BIT      0

// =====================================================================
// Timing counts
`define OVERSAMPLE        5'd16
`define SAMPLE_POINT      4'd7
`define SYNC_HALF         4'd7

`endif

/* File: rtl/serial_channel.v */
/*
 * Serial channel with mode, frame format and clock source selection:
 * asynchronous 7/8-bit framing with parity or multiprocessor bit and
 * 1 or 2 stop bits, and 8-bit clocked synchronous mode.
 * Assumes an APB master on pclk; the serial pins come from outside and
 * are synchronised here. The serial clock pin is sampled, not used as a
 * clock.
 */
// Design decisions made here: the APB interface to the registers and the address map.
`include "serial_channel_map.vh"
`timescale 1ns/100ps
`default_nettype none

module serial_channel
(
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Serial data pins
  input  wire        rxd,
  output reg         txd,
  // Serial clock pin, output enable low while driven
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe_n,
  // Control bits owned by other blocks
  output wire [5:0]  stimer_other
);

  // ===================================================================
  // Registers and pin synchronisers
  reg [7:0]  stimer_ctrl;
  reg [7:0]  fmt;
  reg [7:0]  ctrl;
  reg [7:0]  divisor;
  reg [7:0]  tx_hold;
  reg [7:0]  rx_hold;
  reg        tx_empty;
  reg        rx_full;
  reg        ovr_err;
  reg        frm_err;
  reg        par_err;
  reg        tx_end;
  reg        mpb_rx;
  reg        mpb_tx;
  reg        rx_break;
  reg [1:0]  rxd_sync;
  reg [1:0]  sck_sync;
  reg        sck_last;
  // Transmitter busy is declared here because the clock output reads it.
  reg        tx_busy;
  wire       tx_busy_s = tx_busy;

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;

  // Register access. Flags set by hardware win over a software clear, except TXEMPTY, where a TXDATA write wins.
  wire sync_mode = fmt[`FMT_SYNC_BIT];
  wire mp_on = stimer_ctrl[`STC_MPE_BIT] && fmt[`FMT_MP_BIT]
               && !sync_mode;
  wire seven = fmt[`FMT_CHR_BIT] && !sync_mode;
  wire par_on = fmt[`FMT_PAR_BIT] && !mp_on && !sync_mode;
  wire two_stop = fmt[`FMT_STOP_BIT];
  wire ext_clk = ctrl[`CTL_EXTERNAL_CLOCK_SELECT_BIT];
  wire tx_en = ctrl[`CTL_TXEN_BIT];
  wire rx_en = ctrl[`CTL_RXEN_BIT];

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign stimer_other = {stimer_ctrl[7:3], stimer_ctrl[1]};

  // ===================================================================
  // Bit timing: internal generator or sampled external clock
  reg [7:0] div_cnt;
  reg [3:0] pre_cnt;
  wire      sck_rise = sck_sync[1] && !sck_last;
  wire      sck_fall = !sck_sync[1] && sck_last;
  wire      gen_tick = (div_cnt == divisor);
  // One tick per sixteenth of a bit in async; in sync, per half bit on the internal clock and per bit on the external one.
  wire      tick = ext_clk ? sck_rise : gen_tick;

  // Pin synchronisers: first stage read only by second stage.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_sync <= 2'b11;
      sck_sync <= 2'b00;
      sck_last <= 1'b0;
    end
    else
    begin
      rxd_sync <= {rxd_sync[0], rxd};
      sck_sync <= {sck_sync[0], sck_in};
      sck_last <= sck_sync[1];
    end
  end

  // Divisor runs whenever the generator is selected.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 8'h00;
    else if (gen_tick || ext_clk)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // Bit-rate clock output: low for first half, rises mid-bit.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt <= 4'h0;
      sck_out <= 1'b1;
      sck_oe_n <= 1'b1;
    end
    else
    begin
      if (gen_tick)
        pre_cnt <= pre_cnt + 4'h1;
      if (!sync_mode)
      begin
        sck_oe_n <= !(!ext_clk && ctrl[`CTL_CLOCK_OUTPUT_SELECT_BIT]);
        sck_out <= pre_cnt[3];
      end
      else
      begin
        sck_oe_n <= ext_clk;
        if (ext_clk || !tx_busy_s)
          sck_out <= 1'b1;
        else if (gen_tick)
          sck_out <= !sck_out;
      end
    end
  end

  // ===================================================================
  // Transmitter. Holding register plus shifter gives double buffering.
  reg [10:0] tx_shift;
  reg [3:0]  tx_bits;
  reg [3:0]  tx_sub;
  wire       tx_step = sync_mode ? (ext_clk ? sck_fall :
                       (gen_tick && !sck_out)) :
                       (tick && tx_sub == 4'hF);
  wire [3:0] frame_len = seven ? 4'd8 : 4'd9;
  wire       tx_par = ^tx_hold[7:0] ^ fmt[`FMT_ODD_BIT] ^
                      (seven ? tx_hold[7] : 1'b0);

  // Frame assembled LSB first after the start bit.
  reg [10:0] tx_frame;
  always @*
  begin
    tx_frame = 11'h7FF;
    if (sync_mode)
      tx_frame = {3'b111, tx_hold};
    else if (seven)
      tx_frame = {2'b11, (mp_on ? mpb_tx : par_on ? tx_par : 1'b1),
                  tx_hold[6:0], 1'b0};
    else
      tx_frame = {1'b1, (mp_on ? mpb_tx : par_on ? tx_par : 1'b1),
                  tx_hold, 1'b0};
  end

  // Count of bits from the start bit on: start, data, extra bit, stop bits.
  wire [3:0] tx_total = sync_mode ? 4'd8 :
    frame_len + {3'b000, (mp_on || par_on)} + {3'b000, two_stop} + 4'd1;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_shift <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_sub <= 4'h0;
      tx_busy <= 1'b0;
      txd <= 1'b1;
      tx_end <= 1'b1;
    end
    else if (!tx_en)
    begin
      tx_busy <= 1'b0;
      txd <= 1'b1;
      tx_end <= 1'b1;
    end
    else
    begin
      if (tick && !sync_mode)
        tx_sub <= tx_sub + 4'h1;
      if (!tx_busy && !tx_empty)
      begin
        tx_shift <= tx_frame;
        tx_bits <= tx_total;
        tx_busy <= 1'b1;
        tx_end <= 1'b0;
        tx_sub <= 4'h0;
      end
      else if (tx_busy && tx_step)
      begin
        txd <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[10:1]};
        if (tx_bits == 4'h0)
        begin
          tx_busy <= 1'b0;
          txd <= sync_mode ? txd : 1'b1;
          tx_end <= tx_empty;
        end
        else
          tx_bits <= tx_bits - 4'h1;
      end
    end
  end

  // ===================================================================
  // Receiver. Runs apart from the transmitter, except in sync mode on the internal clock, where it steps only while tx_busy.
  reg [8:0]  rx_shift;
  reg [3:0]  rx_bits;
  reg [3:0]  rx_sub;
  reg        rx_busy;
  reg        rx_done;
  reg        rx_stop_bad;
  wire       rx_line = rxd_sync[1];
  wire       rx_step = sync_mode ? (ext_clk ? sck_rise :
                       (gen_tick && sck_out && tx_busy)) :
                       (tick && rx_sub == `SAMPLE_POINT);
  wire [3:0] rx_total = sync_mode ? 4'd8 :
    frame_len + {3'b000, (mp_on || par_on)};
  // Received parity across data plus parity bit.
  // An extra bit pushes the data one place down and lands in bit 8.
  wire       rx_extra = mp_on || par_on;
  wire [7:0] rx_d8 = rx_extra ? rx_shift[7:0] : rx_shift[8:1];
  wire [6:0] rx_d7 = rx_extra ? rx_shift[7:1] : rx_shift[8:2];
  wire [7:0] rx_data = seven ? {1'b0, rx_d7} : rx_d8;
  wire       rx_xbit = rx_extra && rx_shift[8];
  wire       rx_par_bad = par_on &&
             ((^rx_data) ^ rx_xbit ^ fmt[`FMT_ODD_BIT]);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_shift <= 9'h000;
      rx_bits <= 4'h0;
      rx_sub <= 4'h0;
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_stop_bad <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (!rx_en)
        rx_busy <= 1'b0;
      else if (!rx_busy)
      begin
        if (sync_mode || !rx_line)
        begin
          rx_busy <= sync_mode ? rx_step : 1'b1;
          rx_sub <= 4'h0;
          rx_bits <= sync_mode ? 4'd7 : rx_total;
          if (sync_mode && rx_step)
            rx_shift <= {rx_line, rx_shift[8:1]};
        end
      end
      else
      begin
        if (tick && !sync_mode)
          rx_sub <= rx_sub + 4'h1;
        if (rx_step)
        begin
          if (rx_bits == 4'h0)
          begin
            rx_busy <= 1'b0;
            rx_done <= 1'b1;
            rx_stop_bad <= !sync_mode && !rx_line;
          end
          else
          begin
            rx_bits <= rx_bits - 4'h1;
            rx_shift <= {rx_line, rx_shift[8:1]};
          end
        end
      end
    end
  end

  // ===================================================================
  // Register file and status flags
  wire [7:0] rx_word = sync_mode ? rx_shift[8:1] : rx_data;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stimer_ctrl <= `RST_STIMER_CTRL;
      fmt <= `RST_FORMAT;
      ctrl <= `RST_CTRL;
      divisor <= `RST_DIVISOR;
      tx_hold <= 8'h00;
      rx_hold <= 8'h00;
      tx_empty <= 1'b1;
      rx_full <= 1'b0;
      ovr_err <= 1'b0;
      frm_err <= 1'b0;
      par_err <= 1'b0;
      mpb_rx <= 1'b0;
      mpb_tx <= 1'b0;
      rx_break <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == `OFS_STIMER_CTRL)
        stimer_ctrl <= pwdata[7:0];
      if (wr_en && paddr == `OFS_FORMAT)
        fmt <= pwdata[7:0];
      if (wr_en && paddr == `OFS_CTRL)
        ctrl <= pwdata[7:0];
      if (wr_en && paddr == `OFS_DIVISOR)
        divisor <= pwdata[7:0];
      if (wr_en && paddr == `OFS_TXDATA)
        tx_hold <= pwdata[7:0];
      // Status clears: write zero to the RXFULL, OVR, FRM or PAR flag bit clears it.
      if (wr_en && paddr == `OFS_STATUS)
      begin
        if (!pwdata[`STS_RXFULL_BIT]) rx_full <= 1'b0;
        if (!pwdata[`STS_OVR_BIT]) ovr_err <= 1'b0;
        if (!pwdata[`STS_FRM_BIT]) frm_err <= 1'b0;
        if (!pwdata[`STS_PAR_BIT]) par_err <= 1'b0;
        mpb_tx <= pwdata[`STS_MPBT_BIT];
      end
      if (wr_en && paddr == `OFS_TXDATA)
        tx_empty <= 1'b0;
      else if (!tx_en || (!tx_busy && !tx_empty))
        tx_empty <= 1'b1;
      // Line break: frame error with all-zero data.
      if (rx_done)
        rx_break <= !sync_mode && rx_stop_bad && rx_word == 8'h00;
      if (rx_done)
      begin
        if (rx_full)
          ovr_err <= 1'b1;
        else if (rx_stop_bad || rx_par_bad)
        begin
          frm_err <= rx_stop_bad;
          par_err <= rx_par_bad;
        end
        else
        begin
          rx_hold <= rx_word;
          rx_full <= 1'b1;
          mpb_rx <= mp_on && rx_xbit;
        end
      end
    end
  end

  // Read mux with zero for unmapped addresses.
  always @*
  begin
    prdata = 32'h00000000;
    if (rd_en)
    begin
      case (paddr)
        `OFS_STIMER_CTRL: prdata[7:0] = stimer_ctrl;
        `OFS_FORMAT:      prdata[7:0] = fmt;
        `OFS_CTRL:        prdata[7:0] = ctrl;
        `OFS_DIVISOR:     prdata[7:0] = divisor;
        `OFS_TXDATA:      prdata[7:0] = tx_hold;
        `OFS_RXDATA:      prdata[7:0] = rx_hold;
        `OFS_STATUS:      prdata[8:0] = {rx_break, tx_empty, rx_full,
                                         ovr_err, frm_err, par_err,
                                         tx_end, mpb_rx, mpb_tx};
        default:          prdata = 32'h00000000;
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: bench/serial_channel_sva.sv */
/* Port checker for the serial channel: register mirror, pin roles and
   line levels. Assumes it is bound to every serial_channel instance. */
`timescale 1ns/100ps
`default_nettype none
`include "serial_channel_map.vh"
// ==================================================================
// Checker
module serial_channel_sva
(
  // APB side
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Serial pins
  input wire        rxd,
  input wire        txd,
  input wire        sck_in,
  input wire        sck_out,
  input wire        sck_oe_n,
  input wire [5:0]  stimer_other
);
  reg [7:0] stc_q;
  reg [7:0] fmt_q;
  reg [7:0] ctl_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow copies of register writes, so pin roles can be judged.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stc_q <= 8'h00;
      fmt_q <= 8'h00;
      ctl_q <= 8'h00;
    end
    else if (psel && penable && pwrite)
    begin
      case (paddr)
        `OFS_STIMER_CTRL: stc_q <= pwdata[7:0];
        `OFS_FORMAT:      fmt_q <= pwdata[7:0];
        `OFS_CTRL:        ctl_q <= pwdata[7:0];
        default:          ;
      endcase
    end
  end
  sequence s_wr_stc;
    psel && penable && pwrite && paddr == `OFS_STIMER_CTRL;
  endsequence
  sequence s_rd_stc;
    psel && penable && !pwrite && paddr == `OFS_STIMER_CTRL;
  endsequence
  property p_stc_other;
    s_wr_stc |=> stimer_other == {$past(pwdata[7:3]), $past(pwdata[1])};
  endproperty
  property p_stc_read;
    s_rd_stc |-> prdata == {24'h000000, stc_q};
  endproperty
  property p_pin_unused;
    (!fmt_q[7] && ctl_q[1:0] == 2'b00) [*2] |-> sck_oe_n;
  endproperty
  property p_clk_out;
    (!fmt_q[7] && ctl_q[1:0] == 2'b01) [*2] |-> !sck_oe_n;
  endproperty
  property p_sync_out;
    (fmt_q[7] && !ctl_q[1]) [*2] |-> !sck_oe_n;
  endproperty
  property p_ext_in;
    ctl_q[1] [*2] |-> sck_oe_n;
  endproperty
  // Every async bit lasts sixteen ticks, so no low run is shorter than eight pclk cycles.
  property p_start_len;
    !fmt_q[7] && $fell(txd) |-> !txd [*8];
  endproperty
  property p_idle_reset;
    $rose(presetn) |-> txd && sck_oe_n;
  endproperty
  a_stc_other: assert property (p_stc_other)
    else $error("timer bits not passed on");
  a_stc_read: assert property (p_stc_read)
    else $error("control register read mismatch");
  a_pin_unused: assert property (p_pin_unused)
    else $error("clock pin driven while unused");
  a_clk_out: assert property (p_clk_out)
    else $error("bit rate clock not driven");
  a_sync_out: assert property (p_sync_out)
    else $error("sync clock not driven");
  a_ext_in: assert property (p_ext_in)
    else $error("clock pin driven in external mode");
  a_start_len: assert property (p_start_len)
    else $error("low level too short");
  a_idle_reset: assert property (p_idle_reset)
    else $error("line not idle after reset");
endmodule
bind serial_channel serial_channel_sva chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .rxd(rxd), .txd(txd), .sck_in(sck_in), .sck_out(sck_out),
  .sck_oe_n(sck_oe_n), .stimer_other(stimer_other));
`default_nettype wire

/* File: bench/remote_serial.sv */
/* Remote serial device on the data lines and the clock pin.
   Assumes the bench calls its tasks and sets run_clk directly. */
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// Remote end
module remote_serial
(
  // From the device
  input  wire logic txd,
  // To the device
  output var  logic rxd,
  output var  logic sck
);
  logic run_clk;
  // The line idles at mark; the clock pin stands still when unused.
  initial
  begin
    rxd = 1'b1;
    sck = 1'b0;
    run_clk = 1'b0;
  end
  // Clock at sixteen times the bit rate, only while enabled.
  always #62.5 sck = run_clk ? ~sck : 1'b0;
  // Sends bits from bit 0 on; the frame ends high, leaving the line at mark.
  task automatic send(input logic [12:0] b, input int bitns);
    for (int i = 0; i < 13; i++)
    begin
      rxd = b[i];
      #(bitns);
    end
  endtask
  // Finds a start edge, then samples every bit at its centre.
  task automatic capture(output logic [12:0] b, output logic ok,
                         input int bitns);
    ok = 1'b0;
    for (int n = 0; n < 100000 && !ok; n++)
    begin
      #1;
      ok = (txd === 1'b0);
    end
    #(bitns / 2);
    for (int i = 0; i < 13; i++)
    begin
      b[i] = txd;
      #(bitns);
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
/* Self-checking bench for the serial channel: registers, frame formats,
   receive errors and clock pin roles. Assumes the APB slave answers. */
`timescale 1ns/100ps
`default_nettype none
`include "serial_channel_map.vh"
// ==================================================================
// Bench
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, qd, lfsr = 32'h66C2CCDB;
  logic        pready, pslverr, rxd, txd, sck_in, sck_out, sck_oe_n, ok;
  logic [5:0]  stimer_other;
  logic [12:0] got;
  logic [7:0]  d, fm [7], m;
  logic [8:0]  em [3], ee [3];
  logic [12:0] ef [3];
  int          bad_count = 0, cmp_count = 0;
  serial_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .stimer_other(stimer_other));
  remote_serial far_end (.txd(txd), .rxd(rxd), .sck(sck_in));
  // Clock at 125 MHz.
  always #4 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // Reference frame, bit 0 first: start, data, parity or flag, stops.
  function automatic logic [12:0] frame(input logic [7:0] f, input logic mp,
                                        input logic [7:0] v);
    logic [12:0] b;
    int          n;
    logic        p;
    b = 13'h1FFE;
    n = f[6] ? 7 : 8;
    p = f[4];
    for (int i = 0; i < n; i++)
    begin
      b[i + 1] = v[i];
      p ^= v[i];
    end
    if (mp && f[2])
      b[n + 1] = 1'b1;
    else if (f[5])
      b[n + 1] = p;
    return b;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] v, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      bad_count++;
      conclude();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reprogram with both sections off first, then wait 20 pclk cycles.
  task automatic setup(input logic [7:0] f, input logic mp,
                       input logic [7:0] c);
    apb(1, `OFS_CTRL, 0, qd);
    apb(1, `OFS_STIMER_CTRL, {29'h0, mp, 2'b00}, qd);
    apb(1, `OFS_FORMAT, f, qd);
    apb(1, `OFS_DIVISOR, 0, qd);
    apb(1, `OFS_STATUS, 32'h087, qd);
    apb(1, `OFS_CTRL, c, qd);
    repeat (20) @(posedge pclk);
  endtask
  initial
  begin
    fm = '{8'h00, 8'h40, 8'h20, 8'h78, 8'h04, 8'h24, 8'h4C};
    ef = '{frame(8'h20, 0, 8'h5A) ^ 13'h0200, 13'h1800,
           frame(8'h28, 0, 8'hC3) & 13'h17FF};
    em = '{9'h018, 9'h110, 9'h118};
    ee = '{9'h008, 9'h110, 9'h000};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFS_STIMER_CTRL, 0, q);
    check(q, {24'h0, `RST_STIMER_CTRL});
    apb(0, `OFS_STATUS, 0, q);
    check(q, {24'h0, `RST_STATUS});
    check(sck_oe_n, 1);
    check(pslverr, 0);
    for (int k = 0; k < 4; k++)
    begin
      d = rnd();
      apb(1, `OFS_STIMER_CTRL, {rnd(), d}, qd);
      apb(0, `OFS_STIMER_CTRL, 0, q);
      check(q, {24'h0, d});
      check(stimer_other, {d[7:3], d[1]});
    end
    apb(0, 12'h01C, 0, q);
    check(q, 0);
    $display("test registers done");
    // Each format both ways at once: mode 4 and 6 use the flag bit.
    for (int k = 0; k < 7; k++)
    begin
      setup(fm[k], k == 4 || k == 6, 8'h30);
      d = rnd();
      m = fm[k][6] ? 8'h7F : 8'hFF;
      fork
        apb(1, `OFS_TXDATA, d, qd);
        far_end.capture(got, ok, 128);
        far_end.send(frame(fm[k], k == 4 || k == 6, ~d), 128);
      join
      check(ok, 1);
      check(got, frame(fm[k], k == 4 || k == 6, d));
      apb(0, `OFS_RXDATA, 0, q);
      check(q, {24'h0, ~d & m});
      apb(0, `OFS_STATUS, 0, q);
      check(q[6:3], 4'b1000);
      if (k == 4)
        check(q[1], 1);
    end
    $display("test formats done");
    for (int k = 0; k < 3; k++)
    begin
      setup(k == 2 ? 8'h28 : 8'h20, 0, 8'h30);
      far_end.send(ef[k], 128);
      apb(0, `OFS_STATUS, 0, q);
      check(q & em[k], ee[k]);
    end
    $display("test errors done");
    far_end.run_clk = 1'b1;
    setup(8'h00, 0, 8'h32);
    d = rnd();
    fork
      apb(1, `OFS_TXDATA, d, qd);
      far_end.capture(got, ok, 2000);
    join
    check(got, frame(8'h00, 0, d));
    check(sck_oe_n, 1);
    far_end.run_clk = 1'b0;
    setup(8'h00, 0, 8'h01);
    check(sck_oe_n, 0);
    ok = sck_out;
    repeat (8) @(posedge pclk);
    check(sck_out, !ok);
    setup(8'h80, 0, 8'h00);
    check(sck_oe_n, 0);
    setup(8'h00, 0, 8'h00);
    check(sck_oe_n, 1);
    $display("test clock pin done");
    conclude();
  end
endmodule
`default_nettype wire
